// ==== rtl/cpc_top.sv ====
// Clock path and loop configuration block with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"

module cpc_top #(
  parameter logic [15:0] CAL_CYCLES = `CPC_CAL_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  output logic pump_up,
  output logic pump_down,
  output logic loop_power_down,
  output logic source_internal,
  output logic divider_bypass,
  output logic [2:0] post_div_ratio,
  output logic cal_busy,
  output logic cal_done
);

  typedef struct packed {
    cpc_pkg::cpc_cfg_type staged;
    cpc_pkg::cpc_cfg_type active;
    logic upd_pend;
    logic cal_armed;
    logic cal_busy;
    logic cal_done;
    logic [15:0] cal_cnt;
    logic [2:0] ref_sync;
    logic [2:0] fb_sync;
    logic ref_lvl;
    logic fb_lvl;
    cpc_pkg::cpc_pfd_type phase_detector;
    cpc_pkg::cpc_pump_type pump;
    cpc_pkg::cpc_pump_type pump_out;
    logic [2:0] abl_cnt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic loop_pd;
    logic src_int;
    logic bypass;
    logic [2:0] ratio;
  } cpc_state_type;

  localparam cpc_pkg::cpc_cfg_type CFG_RESET = '{
    loop_power: `CPC_RST_LOOP_POWER,
    polarity: `CPC_RST_POLARITY,
    antibacklash: `CPC_RST_ANTIBACKLASH,
    cal_start: `CPC_RST_CAL_START,
    post_div: `CPC_RST_POST_DIV,
    bypass: `CPC_RST_BYPASS,
    src_int: `CPC_RST_SRC_INT
  };

  cpc_state_type state;
  cpc_state_type next_state;

  function automatic logic is_mapped(input logic [9:0] idx);
    case (idx)
      `CPC_IDX_LOOP_POWER_POLARITY_CTRL,
      `CPC_IDX_ANTIBACKLASH_CTRL,
      `CPC_IDX_OSCILLATOR_CALIBRATION_CTRL,
      `CPC_IDX_POST_DIVIDER_RATIO,
      `CPC_IDX_DISTRIBUTION_SOURCE_SELECT,
      `CPC_IDX_SETTINGS_UPDATE,
      `CPC_IDX_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Byte image of a configuration register, used for staged readback
  function automatic logic [7:0] cfg_byte(input cpc_pkg::cpc_cfg_type c, input logic [9:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      `CPC_IDX_LOOP_POWER_POLARITY_CTRL: begin
        b[`CPC_POS_LOOP_POWER +: 2] = c.loop_power;
        b[`CPC_POS_POLARITY] = c.polarity;
      end
      `CPC_IDX_ANTIBACKLASH_CTRL: b[`CPC_POS_ANTIBACKLASH +: 2] = c.antibacklash;
      `CPC_IDX_OSCILLATOR_CALIBRATION_CTRL: b[`CPC_POS_CAL_START] = c.cal_start;
      `CPC_IDX_POST_DIVIDER_RATIO: b[`CPC_POS_POST_DIV +: 3] = c.post_div;
      `CPC_IDX_DISTRIBUTION_SOURCE_SELECT: begin
        b[`CPC_POS_BYPASS] = c.bypass;
        b[`CPC_POS_SRC_INT] = c.src_int;
      end
      default: b = 8'h00;
    endcase
    cfg_byte = b;
  endfunction : cfg_byte

  // Codes above the largest ratio are held at divide-by-six rather than left undefined
  function automatic logic [2:0] ratio_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `CPC_POST_DIV_MAX_CODE) ? `CPC_POST_DIV_MAX_CODE : code;
    ratio_of = 3'(c + `CPC_POST_DIV_BASE);
  endfunction : ratio_of

  logic [9:0] idx;
  logic access;
  logic wr_take;
  logic transfer;
  logic ref_rise;
  logic fb_rise;
  logic loop_on;

  assign idx = paddr[11:2];
  assign access = psel & penable;
  assign wr_take = access & state.pready & pwrite & ~state.pslverr;
  assign transfer = state.upd_pend;
  assign ref_rise = state.ref_sync[2] & state.ref_sync[1] & ~state.ref_lvl;
  assign fb_rise = state.fb_sync[2] & state.fb_sync[1] & ~state.fb_lvl;
  assign loop_on = (state.active.loop_power == `CPC_LOOP_NORMAL);

  always_comb begin
    next_state = state;

    // APB: one wait state, answer in second access cycle
    next_state.pready = access & ~state.pready;
    next_state.pslverr = access & ~state.pready & ~is_mapped(idx);
    next_state.prdata = 32'h0000_0000;
    if (access & ~state.pready & ~pwrite) begin
      case (idx)
        `CPC_IDX_SETTINGS_UPDATE:
          next_state.prdata[`CPC_POS_UPDATE] = state.upd_pend;
        `CPC_IDX_STATUS:
          next_state.prdata[7:0] = {3'h0, loop_on, state.cal_armed, state.cal_done,
                                    state.cal_busy, state.active.src_int};
        default: next_state.prdata[7:0] = cfg_byte(state.staged, idx);
      endcase
    end

    // Writes land in the staged copy only
    if (wr_take) begin
      case (idx)
        `CPC_IDX_LOOP_POWER_POLARITY_CTRL: begin
          next_state.staged.loop_power = pwdata[`CPC_POS_LOOP_POWER +: 2];
          next_state.staged.polarity = pwdata[`CPC_POS_POLARITY];
        end
        `CPC_IDX_ANTIBACKLASH_CTRL:
          next_state.staged.antibacklash = pwdata[`CPC_POS_ANTIBACKLASH +: 2];
        `CPC_IDX_OSCILLATOR_CALIBRATION_CTRL:
          next_state.staged.cal_start = pwdata[`CPC_POS_CAL_START];
        `CPC_IDX_POST_DIVIDER_RATIO:
          next_state.staged.post_div = pwdata[`CPC_POS_POST_DIV +: 3];
        `CPC_IDX_DISTRIBUTION_SOURCE_SELECT: begin
          next_state.staged.bypass = pwdata[`CPC_POS_BYPASS];
          next_state.staged.src_int = pwdata[`CPC_POS_SRC_INT];
        end
        default: begin
        end
      endcase
    end

    // Pending update clears after its transfer; a new write of 1 wins over the clear
    if (transfer) begin
      next_state.upd_pend = 1'b0;
      next_state.active = state.staged;
    end
    if (wr_take && idx == `CPC_IDX_SETTINGS_UPDATE && pwdata[`CPC_POS_UPDATE]) begin
      next_state.upd_pend = 1'b1;
    end

    // Calibration: one run per arm; a transfer with the bit low re-arms
    if (state.cal_busy) begin
      if (state.cal_cnt == 16'h0000) begin
        next_state.cal_busy = 1'b0;
        next_state.cal_done = 1'b1;
      end else begin
        next_state.cal_cnt = state.cal_cnt - 16'h0001;
      end
    end
    if (transfer) begin
      if (!state.staged.cal_start) begin
        next_state.cal_armed = 1'b1;
      end else if (state.cal_armed && state.staged.src_int && !state.cal_busy) begin
        next_state.cal_armed = 1'b0;
        next_state.cal_busy = 1'b1;
        next_state.cal_done = 1'b0;
        next_state.cal_cnt = CAL_CYCLES - 16'h0001;
      end
    end

    // Three-stage input synchronisers
    next_state.ref_sync = {state.ref_sync[1:0], ref_div_in};
    next_state.fb_sync = {state.fb_sync[1:0], fb_div_in};
    // A new level counts only once the last two stages agree, so a settling bit fakes no edge
    if (state.ref_sync[2] == state.ref_sync[1]) begin
      next_state.ref_lvl = state.ref_sync[2];
    end
    if (state.fb_sync[2] == state.fb_sync[1]) begin
      next_state.fb_lvl = state.fb_sync[2];
    end

    // Phase-frequency detector with antibacklash reset window
    case (state.phase_detector)
      cpc_pkg::CPC_PFD_IDLE,
      cpc_pkg::CPC_PFD_ACTIVE: begin
        if (ref_rise) begin
          next_state.pump.up = 1'b1;
        end
        if (fb_rise) begin
          next_state.pump.down = 1'b1;
        end
        if (next_state.pump.up && next_state.pump.down) begin
          next_state.phase_detector = cpc_pkg::CPC_PFD_RESET;
          next_state.abl_cnt = {1'b0, state.active.antibacklash};
        end else if (next_state.pump.up || next_state.pump.down) begin
          next_state.phase_detector = cpc_pkg::CPC_PFD_ACTIVE;
        end else begin
          next_state.phase_detector = cpc_pkg::CPC_PFD_IDLE;
        end
      end
      cpc_pkg::CPC_PFD_RESET: begin
        // Both pumps held on for antibacklash+1 cycles so small errors never fall dead
        if (state.abl_cnt == 3'h0) begin
          next_state.pump = '{up: 1'b0, down: 1'b0};
          next_state.phase_detector = cpc_pkg::CPC_PFD_IDLE;
        end else begin
          next_state.abl_cnt = state.abl_cnt - 3'h1;
        end
      end
      default: begin
        next_state.phase_detector = cpc_pkg::CPC_PFD_IDLE;
        next_state.pump = '{up: 1'b0, down: 1'b0};
      end
    endcase
    if (!loop_on) begin
      next_state.phase_detector = cpc_pkg::CPC_PFD_IDLE;
      next_state.pump = '{up: 1'b0, down: 1'b0};
      next_state.abl_cnt = 3'h0;
    end

    // Registered path controls follow the active copy
    next_state.loop_pd = !loop_on;
    next_state.src_int = state.active.src_int;
    next_state.bypass = state.active.bypass;
    next_state.ratio = ratio_of(state.active.post_div);

    // Polarity swap is registered so the pump pins come straight from flops
    if (next_state.active.polarity) begin
      next_state.pump_out = '{up: next_state.pump.down, down: next_state.pump.up};
    end else begin
      next_state.pump_out = next_state.pump;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.staged <= CFG_RESET;
      state.active <= CFG_RESET;
      state.upd_pend <= 1'b0;
      state.cal_armed <= 1'b1;
      state.cal_busy <= 1'b0;
      state.cal_done <= 1'b0;
      state.cal_cnt <= 16'h0000;
      state.ref_sync <= 3'h0;
      state.fb_sync <= 3'h0;
      state.ref_lvl <= 1'b0;
      state.fb_lvl <= 1'b0;
      state.phase_detector <= cpc_pkg::CPC_PFD_IDLE;
      state.pump <= '{up: 1'b0, down: 1'b0};
      state.pump_out <= '{up: 1'b0, down: 1'b0};
      state.abl_cnt <= 3'h0;
      state.pready <= 1'b0;
      state.prdata <= 32'h0000_0000;
      state.pslverr <= 1'b0;
      state.loop_pd <= 1'b1;
      state.src_int <= 1'b0;
      state.bypass <= 1'b0;
      state.ratio <= 3'h4;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    pready = state.pready;
    prdata = state.prdata;
    pslverr = state.pslverr;
    pump_up = state.pump_out.up;
    pump_down = state.pump_out.down;
    loop_power_down = state.loop_pd;
    source_internal = state.src_int;
    divider_bypass = state.bypass;
    post_div_ratio = state.ratio;
    cal_busy = state.cal_busy;
    cal_done = state.cal_done;
  end

endmodule : cpc_top
`default_nettype wire

// ==== rtl/cpc_params.svh ====
// Register indices, field positions, reset values and timing counts of the clock path block
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// Register indices; byte address is four times the index
`define CPC_IDX_LOOP_POWER_POLARITY_CTRL 10'h010
`define CPC_IDX_ANTIBACKLASH_CTRL 10'h017
`define CPC_IDX_OSCILLATOR_CALIBRATION_CTRL 10'h018
`define CPC_IDX_POST_DIVIDER_RATIO 10'h1e0
`define CPC_IDX_DISTRIBUTION_SOURCE_SELECT 10'h1e1
`define CPC_IDX_SETTINGS_UPDATE 10'h232
`define CPC_IDX_STATUS 10'h233

// Field positions
`define CPC_POS_LOOP_POWER 0
`define CPC_POS_POLARITY 7
`define CPC_POS_ANTIBACKLASH 0
`define CPC_POS_CAL_START 0
`define CPC_POS_POST_DIV 0
`define CPC_POS_BYPASS 0
`define CPC_POS_SRC_INT 1
`define CPC_POS_UPDATE 0

// Field values
`define CPC_LOOP_NORMAL 2'h0
`define CPC_LOOP_ASYNC_PD 2'h1
`define CPC_POST_DIV_BASE 3'h2
`define CPC_POST_DIV_MAX_CODE 3'h4

// Reset values
`define CPC_RST_LOOP_POWER 2'h1
`define CPC_RST_POLARITY 1'h0
`define CPC_RST_ANTIBACKLASH 2'h0
`define CPC_RST_CAL_START 1'h0
`define CPC_RST_POST_DIV 3'h2
`define CPC_RST_BYPASS 1'h0
`define CPC_RST_SRC_INT 1'h0

// Calibration run length in control clock cycles
`define CPC_CAL_CYCLES 16'h03e8

`endif

// ==== rtl/cpc_pkg.sv ====
// Types shared by the clock path configuration block
package cpc_pkg;

  typedef struct packed {
    logic [1:0] loop_power;
    logic polarity;
    logic [1:0] antibacklash;
    logic cal_start;
    logic [2:0] post_div;
    logic bypass;
    logic src_int;
  } cpc_cfg_type;

  typedef enum logic [2:0] {
    CPC_PFD_IDLE = 3'h1,
    CPC_PFD_ACTIVE = 3'h2,
    CPC_PFD_RESET = 3'h4
  } cpc_pfd_type;

  typedef struct packed {
    logic up;
    logic down;
  } cpc_pump_type;

endpackage : cpc_pkg

// ==== test/cpc_top_props.sv ====
// Port-level checks for the clock path configuration block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module cpc_top_props #(
  parameter logic [15:0] CAL_CYCLES = `CPC_CAL_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic loop_power_down,
  input wire logic source_internal,
  input wire logic divider_bypass,
  input wire logic [2:0] post_div_ratio,
  input wire logic cal_busy,
  input wire logic cal_done
);
  logic upd;
  logic [15:0] run;
  assign upd = psel && penable && pready && pwrite && pwdata[0]
    && paddr[11:2] == `CPC_IDX_SETTINGS_UPDATE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 16'h0000;
    end else begin
      run <= cal_busy ? run + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Three cycles of margin: the pump flops clear one edge after the loop field
  property p_pump_off; loop_power_down [*3] |-> !pump_up && !pump_down; endproperty
  property p_ratio; post_div_ratio >= 3'h2 && post_div_ratio <= 3'h6; endproperty
  property p_staged;
    $changed(source_internal) || $changed(divider_bypass) || $changed(post_div_ratio)
      || $changed(loop_power_down) |-> $past(upd, 2) || $past(upd, 3);
  endproperty
  // Source output follows the transfer one edge after the run starts
  property p_cal_start; $rose(cal_busy) |-> $past(upd, 2) ##1 source_internal;
  endproperty
  property p_cal_len; $fell(cal_busy) |-> run == CAL_CYCLES && cal_done; endproperty
  property p_reset;
    $rose(arst_n) |-> loop_power_down && !source_internal && !divider_bypass
      && post_div_ratio == 3'h4 && !cal_busy && !cal_done;
  endproperty
  property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  property p_err; pslverr |-> pready ##1 !pready; endproperty
  property p_both; pump_up && pump_down |-> ##[1:5] !pump_up && !pump_down; endproperty
  a_pump_off: assert property (p_pump_off) else $error("pumps on with loop off");
  a_ratio: assert property (p_ratio) else $error("ratio out of range");
  a_staged: assert property (p_staged) else $error("path changed without update");
  a_cal_start: assert property (p_cal_start) else $error("bad calibration start");
  a_cal_len: assert property (p_cal_len) else $error("bad calibration length");
  a_reset: assert property (p_reset) else $error("bad reset state");
  a_wait: assert property (p_wait) else $error("bad wait state");
  a_err: assert property (p_err) else $error("bad error response");
  a_both: assert property (p_both) else $error("pulse too long");
  c_cal: cover property ($fell(cal_busy));
  c_err: cover property (pslverr);
  c_both: cover property (pump_up && pump_down);
endmodule : cpc_top_props
`default_nettype wire

// ==== test/cpc_host_model.sv ====
// Host that writes and reads the configuration registers over APB
`timescale 1ns/1ps
`default_nettype none
module cpc_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Request is held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench's own cycle limit ends a stalled wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : cpc_host_model
`default_nettype wire

// ==== test/test_cpc_top.sv ====
// Self-checking bench for the clock path configuration block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module test_cpc_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e, ref_div_in, fb_div_in, pump_up, pump_down;
  logic loop_power_down, source_internal, divider_bypass, cal_busy, cal_done;
  logic [2:0] post_div_ratio;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  cpc_host_model cpc_host_model_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // Short calibration run keeps the bench fast
  cpc_top #(.CAL_CYCLES(16'h0008)) cpc_top_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
    .pump_up(pump_up), .pump_down(pump_down), .loop_power_down(loop_power_down),
    .source_internal(source_internal), .divider_bypass(divider_bypass),
    .post_div_ratio(post_div_ratio), .cal_busy(cal_busy), .cal_done(cal_done));
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    cpc_host_model_i.xfer(1'b1, idx, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic err);
    cpc_host_model_i.xfer(1'b0, idx, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd
  task automatic upd;
    wr(`CPC_IDX_SETTINGS_UPDATE, 32'h1);
    repeat (3) @(posedge clk);
  endtask : upd
  // Order: loop off, internal source, bypass, ratio
  task automatic path(input logic [5:0] exp);
    chk({26'h0, loop_power_down, source_internal, divider_bypass, post_div_ratio}, {26'h0, exp});
  endtask : path
  // Levels alternate so every call makes exactly one rising edge
  task automatic pump_step(input logic r, input logic [1:0] exp);
    ref_div_in <= r;
    fb_div_in <= !r;
    repeat (12) @(posedge clk);
    chk({30'h0, pump_up, pump_down}, {30'h0, exp});
  endtask : pump_step
  task automatic cal_try(input logic exp);
    int n;
    n = 0;
    wr(`CPC_IDX_OSCILLATOR_CALIBRATION_CTRL, 32'h1);
    upd;
    chk({31'h0, cal_busy}, {31'h0, exp});
    while (cal_busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, cal_busy, cal_done}, 32'h1);
  endtask : cal_try
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    ref_div_in <= 1'b0;
    fb_div_in <= 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    path(6'h24);
    rd(`CPC_IDX_LOOP_POWER_POLARITY_CTRL, 32'h1, 1'b0);
    rd(10'h3ff, 32'h0, 1'b1);
    wr(`CPC_IDX_DISTRIBUTION_SOURCE_SELECT, 32'h1);
    path(6'h24);
    upd;
    path(6'h2c);
    rd(`CPC_IDX_SETTINGS_UPDATE, 32'h0, 1'b0);
    wr(`CPC_IDX_DISTRIBUTION_SOURCE_SELECT, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(`CPC_IDX_POST_DIVIDER_RATIO, 32'(i));
      upd;
      path({3'h6, 3'(i + 2)});
    end
    wr(`CPC_IDX_LOOP_POWER_POLARITY_CTRL, 32'h0);
    wr(`CPC_IDX_ANTIBACKLASH_CTRL, 32'h3);
    wr(`CPC_IDX_DISTRIBUTION_SOURCE_SELECT, 32'h1);
    upd;
    path(6'h0e);
    pump_step(1'b1, 2'h2);
    pump_step(1'b0, 2'h0);
    wr(`CPC_IDX_LOOP_POWER_POLARITY_CTRL, 32'h80);
    upd;
    pump_step(1'b1, 2'h1);
    wr(`CPC_IDX_LOOP_POWER_POLARITY_CTRL, 32'h1);
    upd;
    pump_step(1'b0, 2'h0);
    wr(`CPC_IDX_DISTRIBUTION_SOURCE_SELECT, 32'h2);
    cal_try(1'b1);
    cal_try(1'b0);
    wr(`CPC_IDX_OSCILLATOR_CALIBRATION_CTRL, 32'h0);
    upd;
    cal_try(1'b1);
    rd(`CPC_IDX_STATUS, 32'h5, 1'b0);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    path(6'h24);
    tally_and_finish;
  end
endmodule : test_cpc_top
bind cpc_top cpc_top_props #(.CAL_CYCLES(CAL_CYCLES)) cpc_top_props_i (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pump_up(pump_up),
  .pump_down(pump_down), .loop_power_down(loop_power_down),
  .source_internal(source_internal), .divider_bypass(divider_bypass),
  .post_div_ratio(post_div_ratio), .cal_busy(cal_busy), .cal_done(cal_done));
`default_nettype wire
